// ===== pkg/mdt_pkg.sv
// Package of constants for the multichannel decimation timing block
// What this block does
// R1: All channels sample from one shared clock
// R2: All filters start convolution on same cycle
// R3: One word per 64 modulator samples
// R4: Modulator divide 8/4 fast, 40/8 low-power
// R5: Exactly one sample per modulator period
// R6: Settled after 76 words, quiet before 30
// R7: Positive overrange gives code 7FFF
// R8: Negative overrange gives code 8000
// R9: Filter is linear phase, constant delay
// R10: Stop band attenuates out to modulator rate
// R11: Mode input 0 fast, 1 low-power
// R12: Sync low stops and clears filter counters
// R13: Two's complement result, saturate out of range
package mdt_pkg;
    localparam int NUM_CH = 8;
    localparam int OUT_W = 16;
    localparam int OSR = 64;
    localparam logic [5:0] OSR_LAST = 6'h3F;
    // Modulator clock divide ratios
    localparam logic [5:0] DIV_FAST_HI = 6'h08;
    localparam logic [5:0] DIV_FAST_LO = 6'h04;
    localparam logic [5:0] DIV_LOW_HI = 6'h28;
    localparam logic [5:0] DIV_LOW_LO = 6'h08;
    // Settling counts in conversion periods
    localparam logic [6:0] SETTLE_FULL = 7'h4C;
    localparam logic [6:0] SETTLE_QUIET = 7'h1E;
    // Full-scale codes
    localparam logic [15:0] CODE_POS_FS = 16'h7FFF;
    localparam logic [15:0] CODE_NEG_FS = 16'h8000;
    // Accumulator width of the sinc3 integrators
    localparam int ACC_W = 20;
endpackage : mdt_pkg

// ===== design/mdt_moddiv.sv
// Modulator rate divider producing a one-cycle sample enable
`timescale 1ns/10ps
module mdt_moddiv (
    input wire logic mclk,
    input wire logic srst,
    input wire logic run,
    input wire logic low_power,
    input wire logic clock_divide_select,
    output logic mod_en
);
    logic [5:0] cnt_r;
    logic [5:0] ratio;
    // Divide ratio by mode and select
    assign ratio = low_power ?
        (clock_divide_select ? mdt_pkg::DIV_LOW_HI : mdt_pkg::DIV_LOW_LO) :
        (clock_divide_select ? mdt_pkg::DIV_FAST_HI
                             : mdt_pkg::DIV_FAST_LO); // R4
    // Count clocks, pulse once per modulator period
    always_ff @(posedge mclk) begin
        if (srst || !run) begin
            cnt_r <= 6'h00;
            mod_en <= 1'b0;
        end else if (cnt_r >= ratio - 6'h01) begin
            cnt_r <= 6'h00;
            mod_en <= 1'b1; // R5
        end else begin
            cnt_r <= cnt_r + 6'h01;
            mod_en <= 1'b0;
        end
    end
endmodule : mdt_moddiv

// ===== design/mdt_chfilt.sv
// One channel sinc3 decimator with saturation to 16 bits
`timescale 1ns/10ps
module mdt_chfilt (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clr,
    input wire logic mod_en,
    input wire logic dec_en,
    input wire logic bit_in,
    output logic [15:0] word,
    output logic word_vld
);
    localparam int W = mdt_pkg::ACC_W;
    logic signed [W-1:0] i1_r, i2_r, i3_r;
    logic signed [W-1:0] d1_r, d2_r, d3_r;
    logic signed [W-1:0] c1, c2, c3;
    logic signed [W-1:0] x;
    logic signed [W-1:0] scaled;
    logic sat_pos, sat_neg;
    // Bitstream maps to +1 / -1
    assign x = bit_in ? W'(1) : -W'(1);
    // Comb stages, symmetric impulse response
    assign c1 = i3_r - d1_r; // R9
    assign c2 = c1 - d2_r;
    assign c3 = c2 - d3_r;
    // Gain 2^18 scaled down to 16 bits
    assign scaled = c3 >>> 3;
    assign sat_pos = scaled > W'(32767); // R7
    assign sat_neg = scaled < -W'(32768); // R8
    // Integrators run at modulator rate
    always_ff @(posedge mclk) begin
        if (srst || clr) begin
            i1_r <= '0;
            i2_r <= '0;
            i3_r <= '0;
        end else if (mod_en) begin
            i1_r <= i1_r + x; // R10
            i2_r <= i2_r + i1_r;
            i3_r <= i3_r + i2_r;
        end
    end
    // Combs and output at decimated rate
    always_ff @(posedge mclk) begin
        if (srst || clr) begin
            d1_r <= '0;
            d2_r <= '0;
            d3_r <= '0;
            word <= 16'h0000;
            word_vld <= 1'b0;
        end else begin
            word_vld <= dec_en;
            if (dec_en) begin
                d1_r <= i3_r;
                d2_r <= c1;
                d3_r <= c2;
                if (sat_pos)
                    word <= mdt_pkg::CODE_POS_FS; // R13
                else if (sat_neg)
                    word <= mdt_pkg::CODE_NEG_FS; // R13
                else
                    word <= scaled[15:0];
            end
        end
    end
endmodule : mdt_chfilt

// ===== design/mdt_top.sv
// Top of the multichannel decimation timing block
`timescale 1ns/10ps
module mdt_top (
    input wire logic mclk,
    input wire logic srst,
    input wire logic mode_low_power,
    input wire logic clock_divide_select,
    input wire logic sync_n,
    input wire logic [7:0] mod_bits,
    output logic [127:0] data_out,
    output logic data_vld,
    output logic settled,
    output logic quiet
);
    // Three-flop samplers for the pins
    logic [2:0] mode_s_r, div_s_r, sync_s_r;
    logic mode_r, div_r, sync_r;
    logic [7:0] bits_r;
    logic run, mod_en, dec_en, clr;
    logic [5:0] phase_r;
    logic [6:0] settle_r;
    logic mode_old_r, div_old_r;
    logic cfg_change;
    logic [15:0] w [8];
    logic [7:0] wv;
    // Pin synchronisers; change taken when stages 2 and 3 agree
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_s_r <= 3'h0;
            div_s_r <= 3'h0;
            sync_s_r <= 3'h0;
            mode_r <= 1'b0;
            div_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            mode_s_r <= {mode_s_r[1:0], mode_low_power}; // R11
            div_s_r <= {div_s_r[1:0], clock_divide_select};
            sync_s_r <= {sync_s_r[1:0], sync_n};
            if (mode_s_r[1] == mode_s_r[2])
                mode_r <= mode_s_r[2];
            if (div_s_r[1] == div_s_r[2])
                div_r <= div_s_r[2];
            if (sync_s_r[1] == sync_s_r[2])
                sync_r <= sync_s_r[2];
        end
    end
    // Bitstreams registered each clock; all filters take them on mod_en
    always_ff @(posedge mclk) begin
        if (srst)
            bits_r <= 8'h00;
        else
            bits_r <= mod_bits; // R1
    end
    // Mode or divide change restarts the filters
    assign cfg_change = (mode_r != mode_old_r) || (div_r != div_old_r);
    assign run = sync_r && !cfg_change; // R12
    assign clr = !run; // R12
    mdt_moddiv u_div (
        .mclk(mclk),
        .srst(srst),
        .run(run),
        .low_power(mode_r),
        .clock_divide_select(div_r),
        .mod_en(mod_en)
    );
    // Shared decimation phase, one output every 64 samples
    always_ff @(posedge mclk) begin
        if (srst || clr)
            phase_r <= 6'h00;
        else if (mod_en)
            phase_r <= phase_r + 6'h01; // R3
    end
    assign dec_en = mod_en && (phase_r == mdt_pkg::OSR_LAST); // R2
    // Remember last configuration
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_old_r <= 1'b0;
            div_old_r <= 1'b0;
        end else begin
            mode_old_r <= mode_r;
            div_old_r <= div_r;
        end
    end
    // Per-channel filters sharing enables
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_ch
            mdt_chfilt u_f (
                .mclk(mclk),
                .srst(srst),
                .clr(clr),
                .mod_en(mod_en),
                .dec_en(dec_en),
                .bit_in(bits_r[g]),
                .word(w[g]),
                .word_vld(wv[g])
            );
            // Output register per channel
            always_ff @(posedge mclk) begin
                if (srst)
                    data_out[16*g +: 16] <= 16'h0000;
                else if (wv[g])
                    data_out[16*g +: 16] <= w[g];
            end
        end
    endgenerate
    // Settling counter in conversion periods
    always_ff @(posedge mclk) begin
        if (srst || clr) begin
            settle_r <= 7'h00;
            settled <= 1'b0;
            quiet <= 1'b1;
            data_vld <= 1'b0;
        end else begin
            data_vld <= wv[0];
            if (wv[0] && settle_r != mdt_pkg::SETTLE_FULL)
                settle_r <= settle_r + 7'h01;
            settled <= (settle_r == mdt_pkg::SETTLE_FULL); // R6
            quiet <= (settle_r < mdt_pkg::SETTLE_QUIET); // R6
        end
    end
endmodule : mdt_top

// ===== sim/mdt_mod_model.sv
// Modulator bitstream source, full scale of opposite sign per channel
`timescale 1ns/10ps
module mdt_mod_model (
    input wire logic pol,
    output logic [7:0] mod_bits
);
    // Alternate channels get constant ones (positive overrange) and constant zeros (negative)
    assign mod_bits = pol ? 8'hAA : 8'h55;
endmodule : mdt_mod_model

// ===== sim/mdt_checker.sv
// Port assertions for the decimation timing block
`timescale 1ns/10ps
module mdt_checker (
    input wire logic mclk,
    input wire logic srst,
    input wire logic sync_n,
    input wire logic [127:0] data_out,
    input wire logic data_vld,
    input wire logic settled,
    input wire logic quiet
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Cycles since the last word, saturating
    logic [11:0] gap_r;
    always_ff @(posedge mclk) begin
        if (srst || data_vld) gap_r <= 12'h000;
        else if (gap_r != 12'hFFF) gap_r <= gap_r + 12'h001;
    end
    chk_vld_pulse: assert property (data_vld |=> !data_vld)
        else $error("valid longer than one cycle");
    chk_vld_gap: assert property (data_vld |-> gap_r >= 12'h0FF)
        else $error("words closer than 256 cycles");
    chk_gap_max: assert property (settled |-> gap_r <= 12'h9FF)
        else $error("no word within 2560 cycles");
    chk_sync_stop: assert property (!sync_n [*6] |-> !data_vld)
        else $error("word while sync held low");
    chk_sync_clear: assert property (!sync_n [*5] |=> quiet && !settled)
        else $error("flags not cleared by sync");
    chk_flag_excl: assert property (settled |-> !quiet)
        else $error("settled and quiet together");
    chk_out_hold: assert property (!data_vld |-> $stable(data_out))
        else $error("data changed without valid");
    chk_reset_out: assert property (disable iff (1'b0)
        srst |=> quiet && !settled && !data_vld)
        else $error("outputs not cleared by reset");
    cover property (data_vld && settled);
    cover property ($fell(quiet));
    cover property (data_vld && data_out[15:0] == 16'h7FFF);
endmodule : mdt_checker

// ===== sim/mdt_top_tb.sv
// Self-checking bench for the decimation timing block
`timescale 1ns/10ps
module mdt_top_tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic lp = 1'b0;
    logic sel = 1'b0;
    logic sync_n = 1'b1;
    logic pol = 1'b0;
    logic [7:0] mod_bits;
    logic [127:0] data_out;
    logic data_vld;
    logic settled;
    logic quiet;
    int miscompares = 0;
    int samples_checked = 0;
    logic timed_out = 1'b0;
    // 125 MHz clock
    always #4 mclk = ~mclk;
    mdt_mod_model u_mdt_mod_model (.pol(pol), .mod_bits(mod_bits));
    mdt_top u_mdt_top (.mclk(mclk), .srst(srst), .mode_low_power(lp),
        .clock_divide_select(sel), .sync_n(sync_n), .mod_bits(mod_bits),
        .data_out(data_out), .data_vld(data_vld), .settled(settled),
        .quiet(quiet));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // Edges until the next word, bounded
    task automatic wait_vld(output int n);
        n = 0;
        if (timed_out) return;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (data_vld !== 1'b1 && n < 6000);
        if (n >= 6000) begin
            miscompares++;
            timed_out = 1'b1;
        end
    endtask : wait_vld
    task automatic restart;
        @(posedge mclk);
        sync_n <= 1'b0;
        repeat (8) @(posedge mclk);
        sync_n <= 1'b1;
    endtask : restart
    // Word spacing for one mode and divide pair
    task automatic rate_case(input logic l, input logic s, input int r);
        int n;
        @(posedge mclk);
        lp <= l;
        sel <= s;
        restart();
        wait_vld(n);
        wait_vld(n);
        check(16'(n), 16'(64 * r));
    endtask : rate_case
    // Every channel reaches its own full-scale code; only the positive channels saturate, the negative ones land on 8000 exactly
    task automatic data_case(input logic p);
        int n;
        @(posedge mclk);
        pol <= p;
        restart();
        repeat (4) wait_vld(n);
        for (int g = 0; g < 8; g++) begin
            if (g[0] ^ p)
                check(data_out[16*g +: 16], 16'h8000);
            else
                check(data_out[16*g +: 16], 16'h7FFF);
        end
    endtask : data_case
    // Sync hold silence, then settle and quiet word counts
    task automatic settle_case;
        int n;
        int v = 0;
        @(posedge mclk);
        sync_n <= 1'b0;
        repeat (300) begin
            @(posedge mclk);
            #1;
            if (data_vld === 1'b1) v++;
        end
        check(16'(v), 16'h0000);
        check({15'h0000, quiet}, 16'h0001);
        @(posedge mclk);
        sync_n <= 1'b1;
        for (int k = 1; k <= 76; k++) begin
            wait_vld(n);
            repeat (2) @(posedge mclk);
            #1;
            if (k == 29 || k == 30 || k == 75 || k == 76) begin
                check({15'h0000, quiet}, {15'h0000, k < 30});
                check({15'h0000, settled}, {15'h0000, k >= 76});
            end
        end
    endtask : settle_case
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        rate_case(1'b1, 1'b1, 40);
        rate_case(1'b1, 1'b0, 8);
        rate_case(1'b0, 1'b1, 8);
        rate_case(1'b0, 1'b0, 4);
        data_case(1'b0);
        data_case(1'b1);
        settle_case();
        summarize();
    end
endmodule : mdt_top_tb
bind mdt_top mdt_checker u_mdt_checker (.mclk(mclk), .srst(srst),
    .sync_n(sync_n), .data_out(data_out), .data_vld(data_vld),
    .settled(settled), .quiet(quiet));
